// File: inc/vrf_pkg.sv
// Shared constants for the VPS readout and status flag block.
// Assumes one 10 MHz system clock and a synchronous active-low reset.
package vrf_pkg;
  localparam int unsigned VRF_BYTE_W      = 8;
  localparam int unsigned VRF_PTR_W       = 4;
  localparam int unsigned VRF_ACQ_BYTES   = 6;
  localparam int unsigned VRF_ACQ_W       = VRF_ACQ_BYTES * VRF_BYTE_W;
  localparam int unsigned VRF_FIFO_W      = VRF_ACQ_W + 1;
  localparam int unsigned VRF_FIFO_DEPTH  = 2;
  // Positions of VPS bytes inside the acquisition word, then of the error bit just above it
  localparam int unsigned VRF_POS_B5      = 0;
  localparam int unsigned VRF_POS_B11     = 8;
  localparam int unsigned VRF_POS_B12     = 16;
  localparam int unsigned VRF_POS_B13     = 24;
  localparam int unsigned VRF_POS_B14     = 32;
  localparam int unsigned VRF_POS_B15     = 40;
  localparam int unsigned VRF_POS_ERR     = 48;
  // Output byte pointer values
  localparam logic [3:0]  VRF_PTR_FIRST   = 4'h0;
  localparam logic [3:0]  VRF_PTR_LAST    = 4'hf;
  localparam logic [3:0]  VRF_IDX_B1      = 4'h0;
  localparam logic [3:0]  VRF_IDX_B2      = 4'h1;
  localparam logic [3:0]  VRF_IDX_B3      = 4'h2;
  localparam logic [3:0]  VRF_IDX_B4      = 4'h3;
  localparam logic [3:0]  VRF_IDX_B5      = 4'h4;
  localparam logic [3:0]  VRF_IDX_B6      = 4'h5;
  // Constant bytes and reset values
  localparam logic [7:0]  VRF_BYTE_ONES   = 8'hff;
  localparam logic [7:0]  VRF_BYTE_RST    = 8'h00;
  localparam logic [47:0] VRF_STORE_RST   = 48'h0000_0000_0000;
  localparam logic        VRF_VALID_LOW_RST = 1'b1;
  localparam logic        VRF_FIELD_RST   = 1'b0;
  // Slave address pairs
  localparam logic [6:0]  VRF_ADDR_LOW    = 7'h10;
  localparam logic [6:0]  VRF_ADDR_HIGH   = 7'h11;
  localparam logic [7:0]  VRF_WR_ADDR_LOW  = 8'h20;
  localparam logic [7:0]  VRF_RD_ADDR_LOW  = 8'h21;
  localparam logic [7:0]  VRF_WR_ADDR_HIGH = 8'h22;
  localparam logic [7:0]  VRF_RD_ADDR_HIGH = 8'h23;
endpackage : vrf_pkg

// File: src/vrf_buf2.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes a single clock and a synchronous active-low reset.
module vrf_buf2 #(
  parameter int unsigned WIDTH = 49,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
    $error("vrf_buf2 supports exactly two entries");
  end

  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic             wr_idx_reg, wr_idx_next;
  logic             rd_idx_reg, rd_idx_next;
  logic [1:0]       cnt_reg, cnt_next;
  logic             in_ready_reg, in_ready_next;
  logic             push, pop;

  assign in_ready_o  = in_ready_reg;
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rd_idx_reg];

  always_comb begin
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    mem_next    = mem_reg;
    wr_idx_next = wr_idx_reg;
    rd_idx_next = rd_idx_reg;
    cnt_next    = cnt_reg;
    if (push) begin
      mem_next[wr_idx_reg] = in_data_i;
      wr_idx_next          = ~wr_idx_reg;
    end
    if (pop) begin
      rd_idx_next = ~rd_idx_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
    in_ready_next = (cnt_next != 2'h2);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_idx_reg <= 1'b0;
      rd_idx_reg <= 1'b0;
      cnt_reg    <= 2'h0;
      in_ready_reg <= 1'b0;
    end else begin
      mem_reg    <= mem_next;
      wr_idx_reg <= wr_idx_next;
      rd_idx_reg <= rd_idx_next;
      cnt_reg    <= cnt_next;
      in_ready_reg <= in_ready_next;
    end
  end
endmodule : vrf_buf2

// File: src/vrf_readout.sv
// VPS readout byte mapping, transfer store and status flags.
// Assumes I2C framing and line timing logic on the same clock deliver
// one-cycle event pulses; the two pins are asynchronous.

// Functional notes
// [RQ1] Byte 5 is VPS byte 5 reversed
// [RQ2] Byte 6 is VPS byte 15 reversed
// [RQ3] Byte 7 reads as all ones
// [RQ4] Valid flag falls on valid line data
// [RQ5] Valid flag rises at line start
// [RQ6] Valid flag high after reset and no-ack
// [RQ7] Field flag rises at first field
// [RQ8] Field flag falls at second field
// [RQ9] Test mode: flags mirror address select
// [RQ10] Bytes 1-4 are VPS 11-14 reversed
// [RQ11] Start resets pointer, ack advances it
// [RQ12] Store only error-free data when idle
// [RQ13] Address select picks slave address pair
module vrf_readout
  import vrf_pkg::*;
(
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_b_i,
  input  wire logic                         address_select_pin_i,
  input  wire logic                         test_mode_pin_i,
  input  wire logic                         i2c_start_i,
  input  wire logic                         master_ack_i,
  input  wire logic                         master_no_ack_i,
  input  wire logic                         i2c_busy_i,
  input  wire logic                         line16_start_i,
  input  wire logic                         field1_start_i,
  input  wire logic                         field2_start_i,
  input  wire logic [vrf_pkg::VRF_ACQ_W-1:0] acq_data_i,
  input  wire logic                         acq_err_i,
  input  wire logic                         acq_valid_i,
  output logic                              acq_ready_o,
  output logic      [vrf_pkg::VRF_BYTE_W-1:0] rd_byte_o,
  output logic      [vrf_pkg::VRF_PTR_W-1:0] rd_ptr_o,
  output logic      [7:0]                   wr_addr_o,
  output logic      [7:0]                   rd_addr_o,
  output logic                              vps_valid_low_flag_o,
  output logic                              first_field_flag_o
);
  import vrf_pkg::*;

  // Bit order reversal of one byte
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[7-i] = b[i];
    end
    return r;
  endfunction : rev8

  // Slave address for the select level and direction
  function automatic logic [7:0] slave_addr(input logic sel, input logic rd);
    logic [7:0] a;
    if (sel) begin
      a = rd ? VRF_RD_ADDR_HIGH : VRF_WR_ADDR_HIGH; // RQ13
    end else begin
      a = rd ? VRF_RD_ADDR_LOW : VRF_WR_ADDR_LOW; // RQ13
    end
    return a;
  endfunction : slave_addr

  // Refuse sizes the byte map and buffer cannot serve
  if (VRF_ACQ_BYTES != 6 || VRF_BYTE_W != 8) begin : g_bad_map
    $error("vrf_readout needs six 8-bit acquisition bytes");
  end
  if (VRF_PTR_W != 4 || VRF_FIFO_DEPTH != 2) begin : g_bad_ptr
    $error("vrf_readout needs a 4-bit pointer and two buffer entries");
  end

  // Pin synchronisers
  logic [1:0] cs_sync_reg, cs_sync_next;
  logic [1:0] tm_sync_reg, tm_sync_next;
  logic       cs_s, tm_s;

  // Buffer between acquisition and transfer store
  logic [VRF_FIFO_W-1:0] buf_dout;
  logic                  buf_valid;
  logic                  buf_ready;
  logic                  buf_in_ready;

  // Block state
  logic [VRF_ACQ_W-1:0]  store_reg, store_next;
  logic [VRF_PTR_W-1:0]  ptr_reg, ptr_next;
  logic [7:0]            byte_reg, byte_next;
  logic                  valid_low_reg, valid_low_next;
  logic                  field_reg, field_next;
  logic                  out_valid_reg, out_valid_next;
  logic                  out_field_reg, out_field_next;
  logic [7:0]            wr_addr_reg, wr_addr_next;
  logic [7:0]            rd_addr_reg, rd_addr_next;
  logic                  store_en;

  vrf_buf2 #(
    .WIDTH (VRF_FIFO_W),
    .DEPTH (VRF_FIFO_DEPTH)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   ({acq_err_i, acq_data_i}),
    .in_valid_i  (acq_valid_i),
    .in_ready_o  (buf_in_ready),
    .out_data_o  (buf_dout),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_ready)
  );

  assign cs_s      = cs_sync_reg[1];
  assign tm_s      = tm_sync_reg[1];
  assign buf_ready = !i2c_busy_i; // RQ12
  assign store_en  = buf_valid && buf_ready && !buf_dout[VRF_POS_ERR]; // RQ12

  always_comb begin
    cs_sync_next = {cs_sync_reg[0], address_select_pin_i};
    tm_sync_next = {tm_sync_reg[0], test_mode_pin_i};
  end

  always_comb begin
    store_next = store_reg;
    if (store_en) begin
      store_next = buf_dout[VRF_ACQ_W-1:0]; // RQ12
    end
  end

  // Output byte pointer
  always_comb begin
    ptr_next = ptr_reg;
    if (i2c_start_i) begin
      ptr_next = VRF_PTR_FIRST; // RQ11
    end else if (master_ack_i && ptr_reg != VRF_PTR_LAST) begin
      ptr_next = ptr_reg + 4'h1; // RQ11
    end
  end

  // Status flags
  always_comb begin
    valid_low_next = valid_low_reg;
    field_next     = field_reg;
    if (master_no_ack_i) begin
      valid_low_next = 1'b1; // RQ6
    end else if (line16_start_i) begin
      valid_low_next = 1'b1; // RQ5
    end else if (store_en) begin
      valid_low_next = 1'b0; // RQ4
    end
    if (field1_start_i) begin
      field_next = 1'b1; // RQ7
    end else if (field2_start_i) begin
      field_next = 1'b0; // RQ8
    end
  end

  always_comb begin
    case (ptr_next)
      VRF_IDX_B1: byte_next = rev8(store_next[VRF_POS_B11 +: 8]); // RQ10
      VRF_IDX_B2: byte_next = rev8(store_next[VRF_POS_B12 +: 8]); // RQ10
      VRF_IDX_B3: byte_next = rev8(store_next[VRF_POS_B13 +: 8]); // RQ10
      VRF_IDX_B4: byte_next = rev8(store_next[VRF_POS_B14 +: 8]); // RQ10
      VRF_IDX_B5: byte_next = rev8(store_next[VRF_POS_B5 +: 8]); // RQ1
      VRF_IDX_B6: byte_next = rev8(store_next[VRF_POS_B15 +: 8]); // RQ2
      default:    byte_next = VRF_BYTE_ONES; // RQ3
    endcase
  end

  // Pin outputs, flags overridden in test mode
  always_comb begin
    out_valid_next = tm_s ? cs_s : valid_low_next; // RQ9
    out_field_next = tm_s ? cs_s : field_next; // RQ9
    wr_addr_next   = slave_addr(cs_s, 1'b0); // RQ13
    rd_addr_next   = slave_addr(cs_s, 1'b1); // RQ13
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cs_sync_reg <= 2'h0;
      tm_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg <= cs_sync_next;
      tm_sync_reg <= tm_sync_next;
    end
  end

  // Store register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      store_reg <= VRF_STORE_RST;
    end else begin
      store_reg <= store_next;
    end
  end

  // Pointer register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ptr_reg <= VRF_PTR_FIRST;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // Flag registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      valid_low_reg <= VRF_VALID_LOW_RST; // RQ6
      field_reg     <= VRF_FIELD_RST;
    end else begin
      valid_low_reg <= valid_low_next;
      field_reg     <= field_next;
    end
  end

  // Read byte register
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      byte_reg <= VRF_BYTE_RST;
    end else begin
      byte_reg <= byte_next;
    end
  end

  // Pin output registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      out_valid_reg <= VRF_VALID_LOW_RST; // RQ6
      out_field_reg <= VRF_FIELD_RST;
      wr_addr_reg   <= VRF_WR_ADDR_LOW;
      rd_addr_reg   <= VRF_RD_ADDR_LOW;
    end else begin
      out_valid_reg <= out_valid_next;
      out_field_reg <= out_field_next;
      wr_addr_reg   <= wr_addr_next;
      rd_addr_reg   <= rd_addr_next;
    end
  end

  assign acq_ready_o          = buf_in_ready;
  assign rd_byte_o            = byte_reg;
  assign rd_ptr_o             = ptr_reg;
  assign wr_addr_o            = wr_addr_reg;
  assign rd_addr_o            = rd_addr_reg;
  assign vps_valid_low_flag_o = out_valid_reg;
  assign first_field_flag_o   = out_field_reg;
endmodule : vrf_readout

// File: tb/vrf_readout_sva.sv
// Port checker for the readout block.
// Assumes binding onto vrf_readout, one clock, synchronous reset.
module vrf_readout_sva (
  input wire logic       clk_sys_i,
  input wire logic       rst_b_i,
  input wire logic       address_select_pin_i,
  input wire logic       test_mode_pin_i,
  input wire logic       i2c_start_i,
  input wire logic       master_ack_i,
  input wire logic       master_no_ack_i,
  input wire logic       field1_start_i,
  input wire logic       field2_start_i,
  input wire logic       line16_start_i,
  input wire logic       i2c_busy_i,
  input wire logic [7:0] rd_byte_o,
  input wire logic [3:0] rd_ptr_o,
  input wire logic       vps_valid_low_flag_o,
  input wire logic       first_field_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] tm_q;
  logic [3:0] as_q;
  logic       tm;
  always_ff @(posedge clk_sys_i) begin
    tm_q <= rst_b_i ? {tm_q[2:0], test_mode_pin_i} : 4'h0;
    as_q <= {as_q[2:0], address_select_pin_i};
  end
  assign tm = test_mode_pin_i | (|tm_q);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_start_ptr: assert property (i2c_start_i |=> rd_ptr_o == 4'h0)
    else $error("pointer not cleared by start");
  a_ack_ptr: assert property (master_ack_i && !i2c_start_i |=> rd_ptr_o ==
    (($past(rd_ptr_o) == 4'hf) ? 4'hf : $past(rd_ptr_o) + 4'h1))
    else $error("pointer not advanced by ack");
  a_ptr_holds: assert property (!master_ack_i && !i2c_start_i |=> $stable(rd_ptr_o))
    else $error("pointer moved without event");
  a_tail_ones: assert property (rd_ptr_o > 4'h5 |-> rd_byte_o == 8'hff)
    else $error("tail byte not all ones");
  a_line_high: assert property (line16_start_i && !tm |=> vps_valid_low_flag_o)
    else $error("valid flag not raised at line start");
  a_nack_high: assert property (master_no_ack_i && !tm |=> vps_valid_low_flag_o)
    else $error("valid flag not raised by no-ack");
  a_valid_fall: assert property ($fell(vps_valid_low_flag_o) && !tm |->
    !$past(i2c_busy_i))
    else $error("valid flag fell during access");
  a_field_rise: assert property (field1_start_i && !tm |=> first_field_flag_o)
    else $error("field flag not raised");
  a_field_fall: assert property (field2_start_i && !field1_start_i && !tm
    |=> !first_field_flag_o)
    else $error("field flag not lowered");
  a_test_mirror: assert property (&tm_q && test_mode_pin_i &&
    as_q == {4{address_select_pin_i}} |-> vps_valid_low_flag_o == address_select_pin_i
    && first_field_flag_o == address_select_pin_i)
    else $error("flags do not mirror select pin");
endmodule : vrf_readout_sva

bind vrf_readout vrf_readout_sva i_sva (
  .clk_sys_i, .rst_b_i, .address_select_pin_i, .test_mode_pin_i, .i2c_start_i,
  .master_ack_i, .master_no_ack_i, .field1_start_i, .field2_start_i,
  .line16_start_i, .i2c_busy_i, .rd_byte_o, .rd_ptr_o, .vps_valid_low_flag_o,
  .first_field_flag_o);

// File: tb/vrf_host_model.sv
// Host master model giving start, ack, no-ack and busy events.
// Assumes one clock; drives just after its falling edge.
module vrf_host_model (
  input  wire logic clk_sys_i,
  output logic      start_o,
  output logic      ack_o,
  output logic      nack_o,
  output logic      busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {nack_o, ack_o, start_o, busy_o} = 4'h0;
  end
  // Kind 0 start, 1 ack, 2 no-ack, after gap plus one idle cycles
  task automatic pulse(input int k, input int gap);
    repeat (gap + 1) @(negedge clk_sys_i);
    {nack_o, ack_o, start_o} = 3'h1 << k;
    busy_o = (k != 2);
    @(negedge clk_sys_i);
    {nack_o, ack_o, start_o} = 3'h0;
  endtask : pulse
endmodule : vrf_host_model

// File: tb/vrf_readout_tb_top.sv
// Top bench for the readout block with host model and checker.
// Assumes vrf_pkg, the design and the host model compiled first.
module vrf_readout_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import vrf_pkg::*;
  logic        clk_sys_i = 1'b0, rst_b_i = 1'b0, as_pin = 1'b0, tm_pin = 1'b0;
  logic        av = 1'b0, aerr = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [47:0] adata = 48'h0, w, w0;
  logic [7:0]  rbyte, wad, rad;
  logic [3:0]  rptr;
  logic        start, ack, nack, busy, ardy, vflag, fflag;
  logic [31:0] seed = 32'h28;
  int          err_count = 0, checks_done = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  vrf_host_model i_host (.clk_sys_i, .start_o(start), .ack_o(ack), .nack_o(nack),
    .busy_o(busy));
  vrf_readout i_dut (.clk_sys_i, .rst_b_i, .address_select_pin_i(as_pin),
    .test_mode_pin_i(tm_pin), .i2c_start_i(start), .master_ack_i(ack),
    .master_no_ack_i(nack), .i2c_busy_i(busy), .line16_start_i(ev[0]),
    .field1_start_i(ev[1]), .field2_start_i(ev[2]), .acq_data_i(adata),
    .acq_err_i(aerr), .acq_valid_i(av), .acq_ready_o(ardy), .rd_byte_o(rbyte),
    .rd_ptr_o(rptr), .wr_addr_o(wad), .rd_addr_o(rad),
    .vps_valid_low_flag_o(vflag), .first_field_flag_o(fflag));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [47:0] rword();
    logic [31:0] hi;
    hi = rnd();
    return {hi[15:0], rnd()};
  endfunction : rword
  function automatic logic [7:0] exp_byte(input logic [47:0] d, input int p);
    logic [7:0] b, r;
    b = (p < 4) ? d[8+8*p +: 8] : (p == 4) ? d[7:0] : d[47:40];
    for (int i = 0; i < 8; i++) begin
      r[7-i] = b[i];
    end
    return (p > 5) ? 8'hff : r;
  endfunction : exp_byte
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic evp(input logic [2:0] v);
    @(negedge clk_sys_i) ev = v;
    @(negedge clk_sys_i) ev = 3'h0;
  endtask : evp
  task automatic offer(input logic [47:0] d, input logic e);
    int n;
    for (n = 0; n < 50 && ardy !== 1'b1; n++) @(negedge clk_sys_i);
    if (n == 50) begin
      err_count++;
      end_of_test();
    end
    {adata, aerr, av} = {d, e, 1'b1};
    @(negedge clk_sys_i) av = 1'b0;
    repeat (3) @(negedge clk_sys_i);
  endtask : offer
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_b_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    chk(8'(vflag), 8'h1);
    chk(rad, 8'h21);
    chk(wad, 8'h20);
    evp(3'h2);
    chk(8'(fflag), 8'h1);
    evp(3'h4);
    chk(8'(fflag), 8'h0);
    evp(3'h6);
    chk(8'(fflag), 8'h1);
    $display("reset and field test done");
    for (int r = 0; r < 3; r++) begin
      w = rword();
      offer(w, 1'b0);
      chk(8'(vflag), 8'h0);
      i_host.pulse(0, int'(rnd() % 4));
      for (int p = 0; p < 17; p++) begin
        chk(rbyte, exp_byte(w, p > 15 ? 15 : p));
        chk(8'(rptr), 8'(p > 15 ? 15 : p));
        i_host.pulse(p == 16 ? 2 : 1, int'(rnd() % 3));
      end
      chk(8'(vflag), 8'h1);
    end
    $display("readout test done");
    w0 = w;
    w = rword();
    i_host.pulse(0, 0);
    offer(rword(), 1'b0);
    offer(w, 1'b0);
    chk(8'(ardy), 8'h0);
    chk(rbyte, exp_byte(w0, 0));
    i_host.pulse(2, 0);
    repeat (8) @(negedge clk_sys_i);
    chk(8'(vflag), 8'h0);
    evp(3'h1);
    chk(8'(vflag), 8'h1);
    offer(rword(), 1'b1);
    chk(8'(vflag), 8'h1);
    i_host.pulse(0, 0);
    chk(rbyte, exp_byte(w, 0));
    i_host.pulse(2, 0);
    $display("buffer test done");
    tm_pin = 1'b1;
    for (int i = 0; i < 6; i++) begin
      as_pin = rnd() > 32'h7fffffff;
      repeat (5) @(negedge clk_sys_i);
      chk({6'h0, fflag, vflag}, {6'h0, as_pin, as_pin});
      chk(rad, {6'h08, as_pin, 1'b1});
      chk(wad, {6'h08, as_pin, 1'b0});
    end
    tm_pin = 1'b0;
    repeat (5) @(negedge clk_sys_i);
    $display("test mode test done");
    end_of_test();
  end
endmodule : vrf_readout_tb_top
